/* common/smp_pkg.sv */
package smp_pkg;

  // register addresses on the plain register port
  localparam logic [1:0] ADDR_CTL_A = 2'h0;
  localparam logic [1:0] ADDR_CTL_B = 2'h1;
  localparam logic [1:0] ADDR_DATA = 2'h2;

  // serial_port_control_a fields
  localparam int CTLA_MODE_LSB = 5;
  localparam int CTLA_EN_BIT = 1;
  localparam int CTLA_ICF_BIT = 0;

  // serial_port_control_b fields
  localparam int CTLB_POL_BIT = 5;
  localparam int CTLB_EDGE_BIT = 4;
  localparam int CTLB_MLS_BIT = 3;
  localparam int CTLB_CSEN_BIT = 2;
  localparam int CTLB_WCOL_BIT = 1;
  localparam int CTLB_TRF_BIT = 0;

  // reset values
  localparam logic [2:0] MODE_RST = 3'h7;
  localparam logic [7:0] CTLB_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // mode_clock_select encodings
  localparam logic [2:0] MODE_DIV4 = 3'h0;
  localparam logic [2:0] MODE_DIV16 = 3'h1;
  localparam logic [2:0] MODE_DIV64 = 3'h2;
  localparam logic [2:0] MODE_SUB = 3'h3;
  localparam logic [2:0] MODE_TMR = 3'h4;
  localparam logic [2:0] MODE_SLAVE = 3'h5;
  localparam logic [1:0] MODE_OFF_HI = 2'h3;

  // last count of a half serial clock period, in system clocks minus one
  localparam logic [4:0] HALF_DIV4_LAST = 5'h01;
  localparam logic [4:0] HALF_DIV16_LAST = 5'h07;
  localparam logic [4:0] HALF_DIV64_LAST = 5'h1f;

  // serial clock edges in one byte (eight clock periods)
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

  typedef enum logic {SMP_IDLE, SMP_SHIFT} smp_state_e;

endpackage : smp_pkg

/* verilog/smp_clkdiv.sv */
`timescale 1ns/1ps

module smp_clkdiv
  import smp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic run, // master transfer in progress
  input wire logic [2:0] mode, // clock source select
  input wire logic sub_tick, // sub clock half-period pulse
  input wire logic tmr_tick, // timer match pulse
  output logic tick // half-period pulse, registered
);

  typedef struct packed {
    logic [4:0] cnt;
    logic tick;
  } smp_div_s;

  smp_div_s q;
  smp_div_s d;
  logic [4:0] last;

  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    last = HALF_DIV4_LAST;
    unique case (mode)
      MODE_DIV16: last = HALF_DIV16_LAST;
      MODE_DIV64: last = HALF_DIV64_LAST;
      default: last = HALF_DIV4_LAST;
    endcase
    if (!run)
    begin
      d.cnt = 5'h00;
    end
    else if (mode == MODE_SUB)
    begin
      d.tick = sub_tick;
    end
    else if (mode == MODE_TMR)
    begin
      d.tick = tmr_tick;
    end
    else if (q.cnt == last)
    begin
      d.cnt = 5'h00;
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule : smp_clkdiv

/* verilog/smp_port.sv */
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

// Notes on behaviour
// - select_pin_enable set makes slave_select_n a live select line; clear floats it.
// - data write during a transfer is dropped and sets write_collision_flag.
// - write_collision_flag set only by hardware, cleared by software writing zero.
// - transfer_complete_flag set when a byte ends, cleared only by software.
// - transfer_complete_flag drives the interrupt request output.
// - enabled master starts a full-duplex transfer on a data write.
// - slave shifts data out and in on edges from the external master.
// - slave presents each output bit ahead of the chosen sampling edge.
// - port keeps working in idle states while its clock source runs.
// - enabled idle master or unselected slave drives serial_data_out high, input floats.
// - enabled master holds serial clock at the polarity idle level.
// - enabled slave never drives the serial clock line.
// - port_enable low releases all four serial pins.
// - master makes its own clock; slave uses only the external one.
// - received bits collect in shift_buffer and copy over when complete.
// - master and slave share the same bit order setting.
// - mode field picks master clock source, slave, or disable.
// - polarity picks idle level; active edge bit picks capture edge.
// - bit_order_select one shifts MSB first, zero LSB first.
// - slave deselected mid-byte sets incomplete and complete flags.
module smp_port
  import smp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [1:0] addr, // register address
  input wire logic [7:0] wdata, // register write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic sub_clk_tick, // sub clock half-period pulse
  input wire logic timer_match_tick, // timer period match pulse
  input wire logic serial_data_in, // serial input pin
  output logic serial_data_out, // serial output pin level
  output logic serial_data_out_oe, // serial output drive enable
  input wire logic serial_clock_line_in, // serial clock pin level
  output logic serial_clock_line_out, // serial clock drive level
  output logic serial_clock_line_oe, // serial clock drive enable
  input wire logic slave_select_n_in, // select pin level
  output logic slave_select_n_out, // select drive level
  output logic slave_select_n_oe, // select drive enable
  output logic pins_claimed, // port owns its pins
  output logic transfer_irq // transfer complete request
);

  typedef struct packed {
    logic [2:0] mode;
    logic en;
    logic icf;
    logic pol;
    logic ckeg;
    logic mls;
    logic csen;
    logic wcol;
    logic trf;
    logic [7:0] data;
    logic [7:0] txsh;
    logic [7:0] rxsh;
    smp_state_e st;
    logic [4:0] edges;
    logic sck;
    logic sck_prev;
    logic [7:0] rdata;
    logic sdo;
    logic sdo_oe;
    logic sck_oe;
    logic ss;
    logic ss_oe;
    logic claimed;
    logic irq;
  } smp_regs_s;

  smp_regs_s q;
  smp_regs_s d;
  logic active;
  logic is_master;
  logic is_slave;
  logic selected;
  logic busy;
  logic wr_data;
  logic wr_ctla;
  logic wr_ctlb;
  logic div_tick;
  logic edge_ev;
  logic leading;
  logic sample;
  logic shift_out;
  logic finish;
  logic abort;
  logic start;
  logic [7:0] rx_next;
  logic [7:0] tx_next;

  assign active = q.en && (q.mode[2:1] != MODE_OFF_HI);
  assign is_master = active && (q.mode != MODE_SLAVE);
  assign is_slave = active && (q.mode == MODE_SLAVE);
  assign selected = is_slave && (!q.csen || !slave_select_n_in);
  assign busy = (q.st == SMP_SHIFT);
  assign wr_data = wr && (addr == ADDR_DATA);
  assign wr_ctla = wr && (addr == ADDR_CTL_A);
  assign wr_ctlb = wr && (addr == ADDR_CTL_B);
  assign start = is_master && !busy && wr_data;

  // master edges come from the divider, slave edges from the pin
  assign edge_ev = is_master ? (div_tick && busy)
                             : (selected && (serial_clock_line_in != q.sck_prev));
  assign leading = is_master ? !q.edges[0] : (serial_clock_line_in == q.pol);
  assign sample = (leading == q.ckeg);
  assign shift_out = !sample && (q.edges != 5'h00);
  assign finish = edge_ev && (q.edges == EDGES_PER_BYTE - 5'h01);
  assign abort = is_slave && busy && q.csen && slave_select_n_in;
  assign rx_next = !sample ? q.rxsh :
                   q.mls ? {q.rxsh[6:0], serial_data_in}
                         : {serial_data_in, q.rxsh[7:1]};
  assign tx_next = q.mls ? {q.txsh[6:0], 1'b0} : {1'b0, q.txsh[7:1]};

  smp_clkdiv u_div (
    .clk(clk),
    .rst(rst),
    .run(is_master && busy),
    .mode(q.mode),
    .sub_tick(sub_clk_tick),
    .tmr_tick(timer_match_tick),
    .tick(div_tick)
  );

  always_comb
  begin
    d = q;
    d.sck_prev = serial_clock_line_in;
    if (wr_ctla)
    begin
      d.mode = wdata[CTLA_MODE_LSB +: 3];
      d.en = wdata[CTLA_EN_BIT];
      d.icf = wdata[CTLA_ICF_BIT];
    end
    if (wr_ctlb)
    begin
      d.pol = wdata[CTLB_POL_BIT];
      d.ckeg = wdata[CTLB_EDGE_BIT];
      d.mls = wdata[CTLB_MLS_BIT];
      d.csen = wdata[CTLB_CSEN_BIT];
      d.wcol = q.wcol && wdata[CTLB_WCOL_BIT];
      d.trf = q.trf && wdata[CTLB_TRF_BIT];
    end
    if (!busy)
    begin
      d.txsh = q.data;
      d.sck = ~q.pol;
    end
    if (wr_data)
    begin
      if (busy)
      begin
        d.wcol = 1'b1;
      end
      else
      begin
        d.data = wdata;
      end
    end
    if (start)
    begin
      d.txsh = wdata;
      d.st = SMP_SHIFT;
      d.edges = 5'h00;
    end
    if (edge_ev)
    begin
      if (is_master)
      begin
        d.sck = ~q.sck;
      end
      d.rxsh = rx_next;
      if (shift_out)
      begin
        d.txsh = tx_next;
      end
      d.st = SMP_SHIFT;
      d.edges = q.edges + 5'h01;
    end
    if (finish)
    begin
      d.st = SMP_IDLE;
      d.edges = 5'h00;
      d.data = rx_next;
      d.trf = 1'b1;
    end
    if (abort)
    begin
      d.st = SMP_IDLE;
      d.edges = 5'h00;
      d.icf = 1'b1;
      d.trf = 1'b1;
    end
    if (!active)
    begin
      d.st = SMP_IDLE;
      d.edges = 5'h00;
    end
    // pin drive, registered
    d.claimed = active;
    d.sdo_oe = active;
    d.sdo = ((d.st == SMP_SHIFT) || selected)
            ? (q.mls ? d.txsh[7] : d.txsh[0]) : 1'b1;
    d.sck_oe = is_master;
    d.ss_oe = is_master && q.csen;
    d.ss = (d.st != SMP_SHIFT);
    d.irq = q.trf;
    d.rdata = 8'h00;
    if (rd)
    begin
      unique case (addr)
        ADDR_CTL_A: d.rdata = {q.mode, 3'h0, q.en, q.icf};
        ADDR_CTL_B: d.rdata = {2'h0, q.pol, q.ckeg, q.mls, q.csen, q.wcol, q.trf};
        ADDR_DATA: d.rdata = q.data;
        default: d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.mode <= MODE_RST;
      {q.pol, q.ckeg, q.mls, q.csen, q.wcol, q.trf} <= CTLB_RST[5:0];
      q.data <= DATA_RST;
      q.sdo <= 1'b1;
      q.ss <= 1'b1;
      q.sck <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign serial_data_out = q.sdo;
  assign serial_data_out_oe = q.sdo_oe;
  assign serial_clock_line_out = q.sck;
  assign serial_clock_line_oe = q.sck_oe;
  assign slave_select_n_out = q.ss;
  assign slave_select_n_oe = q.ss_oe;
  assign pins_claimed = q.claimed;
  assign transfer_irq = q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_wcol_set;
    wr_data && busy |=> q.wcol;
  endproperty
  a_wcol_set: assert property (p_wcol_set) else $error("collision flag not set");

  property p_data_kept;
    wr_data && busy && !finish |=> q.data == $past(q.data);
  endproperty
  a_data_kept: assert property (p_data_kept) else $error("colliding write stored");

  property p_wcol_hw_only;
    $rose(q.wcol) |-> $past(wr_data && busy);
  endproperty
  a_wcol_hw_only: assert property (p_wcol_hw_only) else $error("collision flag rose alone");

  property p_trf_sticky;
    q.trf && !(wr_ctlb && !wdata[CTLB_TRF_BIT]) |=> q.trf;
  endproperty
  a_trf_sticky: assert property (p_trf_sticky) else $error("complete flag dropped");

  property p_irq_follows;
    q.trf ##1 q.trf |-> transfer_irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq not following flag");

  property p_master_start;
    start |=> busy && (q.txsh == $past(wdata)) && !slave_select_n_out;
  endproperty
  a_master_start: assert property (p_master_start) else $error("master did not start");

  property p_sdo_idle_high;
    is_master && !busy && !wr_data |=> serial_data_out && serial_data_out_oe;
  endproperty
  a_sdo_idle_high: assert property (p_sdo_idle_high) else $error("idle output not high");

  property p_sck_idle;
    is_master && !busy && !wr_data |=> serial_clock_line_out == ~$past(q.pol);
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("idle clock level wrong");

  property p_slave_no_sck;
    is_slave |=> !serial_clock_line_oe;
  endproperty
  a_slave_no_sck: assert property (p_slave_no_sck) else $error("slave drove clock");

  property p_release;
    !active |=> !serial_data_out_oe && !serial_clock_line_oe && !slave_select_n_oe
                && !pins_claimed;
  endproperty
  a_release: assert property (p_release) else $error("pins held while disabled");

  property p_incomplete;
    abort |=> q.icf && q.trf && !busy;
  endproperty
  a_incomplete: assert property (p_incomplete) else $error("incomplete not flagged");

  property p_byte_len;
    start && (q.mode == MODE_DIV4) |-> ##33 (finish || !is_master || q.mode != MODE_DIV4);
  endproperty
  a_byte_len: assert property (p_byte_len) else $error("byte length wrong");

  c_master_done: cover property (is_master && finish);
  c_slave_done: cover property (is_slave && finish);
  c_collision: cover property (wr_data && busy);
  c_abort: cover property (abort);

endmodule : smp_port

/* verif/smp_peer.sv */
`timescale 1ns/1ps

module smp_peer (
  input wire logic clk, // clock
  input wire logic pol, // idle low
  input wire logic edge_cap, // capture on lead
  input wire logic msb, // msb first
  input wire logic go, // load, start
  input wire logic as_master, // peer clocks
  input wire logic [4:0] nedge, // edges made
  input wire logic [7:0] tx, // byte out
  input wire logic sck, // clock line
  input wire logic sdo, // device out
  output logic sdi, // device in
  output logic sck_drv = 1, // clock drive
  output logic ss_n = 1, // select drive
  output logic [7:0] rx = 0 // byte in
);
  int n = 0;
  int dly = 0;
  logic act = 0;
  logic junk = 0;
  logic sck_q = 1;
  // line level at the instant of the clock edge, since edges are seen one cycle late
  logic sdo_q = 1;
  logic [7:0] sh = 0;
  // a released data line toggles so a stale bit never passes as valid
  assign sdi = act ? (msb ? sh[7] : sh[0]) : junk;
  always @(posedge clk)
  begin
    junk <= ~junk;
    sck_q <= sck;
    sdo_q <= sdo;
    dly <= (n >= 16) ? dly + 1 : 0;
    if (dly == 4)
      act <= 0;
    if (go)
    begin
      sh <= tx;
      n <= 0;
      act <= 1;
    end
    else if (sck != sck_q)
    begin
      n <= n + 1;
      if ((n % 2 == 0) == edge_cap)
        rx <= msb ? {rx[6:0], sdo_q} : {sdo_q, rx[7:1]};
      else if (n != 0)
        sh <= msb ? sh << 1 : sh >> 1;
    end
  end
  // clock rests at its idle level outside frames
  always @(posedge clk)
    if (go && as_master)
    begin
      ss_n <= 0;
      repeat (6) @(posedge clk);
      repeat (nedge)
      begin
        sck_drv <= ~sck_drv;
        repeat (6) @(posedge clk);
      end
      ss_n <= 1;
    end
    else
      sck_drv <= ~pol;
endmodule : smp_peer

/* verif/testbench.sv */
`timescale 1ns/1ps

module testbench
  import smp_pkg::*;
;
  logic clk = 0;
  logic rst = 1;
  logic [1:0] addr = 0;
  logic [7:0] wdata = 0;
  logic wr = 0;
  logic rd = 0;
  logic sub_tick = 0;
  logic tmr_tick = 0;
  logic go = 0;
  logic pm = 0;
  logic ss_blk = 0;
  logic sck_prev = 1;
  logic [2:0] pc = 0;
  logic [4:0] ne = 16;
  logic [7:0] ptx = 0;
  logic [7:0] rdata, prx;
  logic sdi, sdo, sdo_oe, sck_out, sck_oe, ss_n_out, ss_oe, pins, irq, p_sck, p_ss_n;
  int seed = 60;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int edges = 0;
  wire sck_line = sck_oe ? sck_out : p_sck;
  wire ss_n_line = ss_oe ? ss_n_out : (p_ss_n | ss_blk);
  wire sdo_line = sdo_oe ? sdo : 1'b1;

  smp_port u_smp_port (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sub_clk_tick(sub_tick), .timer_match_tick(tmr_tick),
    .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_out_oe(sdo_oe),
    .serial_clock_line_in(sck_line), .serial_clock_line_out(sck_out),
    .serial_clock_line_oe(sck_oe), .slave_select_n_in(ss_n_line),
    .slave_select_n_out(ss_n_out), .slave_select_n_oe(ss_oe), .pins_claimed(pins),
    .transfer_irq(irq));

  smp_peer u_smp_peer (.clk(clk), .pol(pc[2]), .edge_cap(pc[1]), .msb(pc[0]), .go(go),
    .as_master(pm), .nedge(ne), .tx(ptx), .sck(sck_line), .sdo(sdo_line), .sdi(sdi),
    .sck_drv(p_sck), .ss_n(p_ss_n), .rx(prx));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    sub_tick <= (cyc % 3 == 0);
    tmr_tick <= (cyc % 5 == 0);
    sck_prev <= sck_line;
    if (go)
      edges <= 0;
    else if (sck_oe && sck_line != sck_prev)
      edges <= edges + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // go rides on the write strobe so the peer starts in step with the bus
  task automatic wreg(input logic [1:0] a, input logic [7:0] d, input logic st);
    addr <= a;
    wdata <= d;
    wr <= 1;
    go <= st;
    @(posedge clk);
    wr <= 0;
    go <= 0;
    @(posedge clk);
  endtask : wreg

  task automatic rchk(input logic [1:0] a, input logic [7:0] exp, input string what);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(posedge clk);
    chk(what, rdata, exp);
  endtask : rchk

  task automatic pin_chk(input logic [4:0] exp);
    @(negedge clk);
    chk("pins", {3'h0, pins, sdo_oe, sck_oe, ss_oe, sck_line}, {3'h0, exp});
    @(posedge clk);
  endtask : pin_chk

  task automatic wait_irq();
    for (int i = 0; i < 3000 && irq !== 1'b1; i++)
      @(posedge clk);
  endtask : wait_irq

  task automatic master_run(input logic [2:0] m, input logic cs);
    logic [7:0] tx;
    logic [2:0] c;
    tx = 8'($random(seed));
    c = {2'($random(seed)), m[0]};
    pc <= c;
    ptx <= 8'($random(seed));
    pm <= 0;
    wreg(ADDR_CTL_B, {2'h0, c, cs, 2'h0}, 0);
    wreg(ADDR_CTL_A, {m, 5'h02}, 0);
    rchk(ADDR_CTL_A, {m, 5'h02}, "mode");
    pin_chk({3'h7, cs, !pc[2]});
    chk("sdo idle", sdo_line, 8'h01);
    wreg(ADDR_DATA, tx, 1);
    wreg(ADDR_DATA, ~tx, 0);
    chk("select", ss_n_line, !cs);
    wait_irq();
    chk("edges", 8'(edges), 8'h10);
    chk("irq", irq, 8'h01);
    rchk(ADDR_CTL_B, {2'h0, pc, cs, 2'h3}, "flags");
    rchk(ADDR_DATA, ptx, "rx");
    chk("peer rx", prx, tx);
    wreg(ADDR_CTL_B, {2'h0, pc, cs, 2'h0}, 0);
    rchk(ADDR_CTL_B, {2'h0, pc, cs, 2'h0}, "cleared");
  endtask : master_run

  task automatic slave_run(input logic cs, input logic [4:0] n);
    logic [7:0] tx;
    tx = 8'($random(seed));
    pc <= 3'($random(seed));
    ptx <= 8'($random(seed));
    pm <= 1;
    ne <= n;
    ss_blk <= !cs;
    wreg(ADDR_CTL_A, 8'h00, 0);
    pin_chk({4'h0, !pc[2]});
    wreg(ADDR_CTL_B, {2'h0, pc, cs, 2'h0}, 0);
    wreg(ADDR_CTL_A, {MODE_SLAVE, 5'h02}, 0);
    pin_chk({4'hc, !pc[2]});
    wreg(ADDR_DATA, tx, 0);
    wreg(2'h3, 8'hff, 1);
    wait_irq();
    rchk(ADDR_CTL_A, {MODE_SLAVE, 4'h1, n != 16}, "icf");
    rchk(ADDR_CTL_B, {2'h0, pc, cs, 2'h1}, "slave flags");
    rchk(ADDR_DATA, (n == 16) ? ptx : tx, "slave rx");
    if (n == 16)
      chk("peer rx", prx, tx);
    wreg(ADDR_CTL_B, {2'h0, pc, cs, 2'h0}, 0);
  endtask : slave_run

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 0;
    rchk(ADDR_CTL_A, 8'he0, "reset a");
    rchk(ADDR_CTL_B, CTLB_RST, "reset b");
    rchk(ADDR_DATA, DATA_RST, "reset data");
    rchk(2'h3, 8'h00, "unmapped");
    for (int i = 0; i < 10; i++)
      master_run(3'(i % 5), i < 5);
    slave_run(1, 16);
    slave_run(0, 16);
    slave_run(1, 16);
    slave_run(1, 6);
    wreg(ADDR_CTL_A, 8'hc2, 0);
    pin_chk({4'h0, !pc[2]});
    wreg(ADDR_CTL_A, 8'he2, 0);
    pin_chk({4'h0, !pc[2]});
    print_verdict();
  end
endmodule : testbench
